// ---- hw/abu_pkg.sv ----
// Package for the address breakpoint unit: register map, fields, reset values
package abu_pkg;
  localparam logic [7:0] ABU_OFF_CTRL = 8'h00;
  localparam logic [7:0] ABU_OFF_ADDR_HI = 8'h04;
  localparam logic [7:0] ABU_OFF_ADDR_LO = 8'h08;
  localparam logic [7:0] ABU_OFF_AUX = 8'h0C;
  localparam logic [7:0] ABU_OFF_WAIT_STAT = 8'h10;
  localparam logic [7:0] ABU_OFF_FLAG_CTRL = 8'h14;
  localparam int ABU_BIT_ENABLE = 7;
  localparam int ABU_BIT_ACTIVE = 6;
  localparam int ABU_BIT_WDOG_DIS = 0;
  localparam int ABU_BIT_WAIT_EXIT = 1;
  localparam int ABU_BIT_CLR_EN = 7;
  localparam logic [7:0] ABU_RST_BYTE = 8'h00;
  localparam logic [15:0] ABU_VEC_NORMAL = 16'hFFFC;
  localparam logic [15:0] ABU_VEC_MONITOR = 16'hFEFC;
  localparam logic [7:0] ABU_SWI_OPCODE = 8'h01;

  typedef struct packed {
    logic [15:0] addr;
    logic opcode_fetch;
    logic instr_boundary;
    logic rti_done;
  } abu_cpu_t;

  typedef struct packed {
    logic wait_mode;
    logic stop_mode;
    logic monitor_mode;
    logic emulation_mode;
    logic wait_exit;
  } abu_sys_t;

  typedef enum logic [1:0] {
    ABU_IDLE = 2'b00,
    ABU_PEND = 2'b01,
    ABU_BREAK = 2'b10
  } abu_state_t;
endpackage

// ---- hw/abu_top.sv ----
// Address breakpoint unit with APB register slave
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/100ps
module abu_top
  import abu_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire abu_pkg::abu_cpu_t cpu,
  input wire abu_pkg::abu_sys_t sys,
  output logic breakpoint_request,
  output logic [15:0] break_vector,
  output logic [7:0] software_interrupt_opcode,
  output logic in_break,
  output logic timer_halt,
  output logic watchdog_suppress,
  output logic flag_clear_allowed
);
  import abu_pkg::*;

  logic rst_meta;
  logic rst_n;
  logic [7:0] break_address_high;
  logic [7:0] break_address_low;
  logic break_enable_bit;
  logic break_active_bit;
  logic break_watchdog_disable;
  logic wait_exit_by_break_flag;
  logic break_flag_clear_enable;
  logic armed;
  abu_state_t state;
  logic wr_acc;
  logic rd_acc;
  logic addr_hit;
  logic mapped;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign mapped = (paddr == ABU_OFF_CTRL) || (paddr == ABU_OFF_ADDR_HI) ||
    (paddr == ABU_OFF_ADDR_LO) || (paddr == ABU_OFF_AUX) ||
    (paddr == ABU_OFF_WAIT_STAT) || (paddr == ABU_OFF_FLAG_CTRL);

  // CPU program-counter address, enabled, not in low power, armed
  assign addr_hit = cpu.opcode_fetch && break_enable_bit && armed &&
    (cpu.addr == {break_address_high, break_address_low}) &&
    !sys.wait_mode && !sys.stop_mode;

  // Address registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      break_address_high <= ABU_RST_BYTE;
      break_address_low <= ABU_RST_BYTE;
    end
    else if (wr_acc && paddr == ABU_OFF_ADDR_HI)
      break_address_high <= pwdata[7:0];
    else if (wr_acc && paddr == ABU_OFF_ADDR_LO)
      break_address_low <= pwdata[7:0];
  end

  // Control bits
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      break_enable_bit <= 1'b0;
      break_watchdog_disable <= 1'b0;
      break_flag_clear_enable <= 1'b0;
    end
    else if (wr_acc)
    begin
      if (paddr == ABU_OFF_CTRL)
        break_enable_bit <= pwdata[ABU_BIT_ENABLE];
      if (paddr == ABU_OFF_AUX)
        break_watchdog_disable <= pwdata[ABU_BIT_WDOG_DIS];
      if (paddr == ABU_OFF_FLAG_CTRL)
        break_flag_clear_enable <= pwdata[ABU_BIT_CLR_EN];
    end
  end

  // Active bit: hardware set wins over software clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      break_active_bit <= 1'b0;
    else if (addr_hit)
      break_active_bit <= 1'b1;
    else if (wr_acc && paddr == ABU_OFF_CTRL)
      break_active_bit <= pwdata[ABU_BIT_ACTIVE];
  end

  // Clearing the active bit in the break state with an unchanged address disarms further matches
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      armed <= 1'b1;
    else if (wr_acc && (paddr == ABU_OFF_ADDR_HI || paddr == ABU_OFF_ADDR_LO))
      armed <= 1'b1;
    else if (wr_acc && paddr == ABU_OFF_CTRL && !pwdata[ABU_BIT_ACTIVE] &&
      state == ABU_BREAK)
      armed <= 1'b0;
  end

  // Wait-exit flag only meaningful in emulation mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wait_exit_by_break_flag <= 1'b0;
    else if (sys.emulation_mode && sys.wait_exit && state == ABU_PEND)
      wait_exit_by_break_flag <= 1'b1;
    else if (state == ABU_IDLE)
      wait_exit_by_break_flag <= 1'b0;
  end

  // Break sequencing: request pends until the next instruction boundary
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ABU_IDLE;
    end
    else
    begin
      case (state)
        ABU_IDLE:
        begin
          if (addr_hit || (wr_acc && paddr == ABU_OFF_CTRL && pwdata[ABU_BIT_ACTIVE]))
            state <= ABU_PEND;
        end
        ABU_PEND:
          // Any pending break, address match or software, is taken at the next instruction boundary
          if (cpu.instr_boundary)
            state <= ABU_BREAK;
        ABU_BREAK:
          if (cpu.rti_done)
            state <= ABU_IDLE;
        default:
          state <= ABU_IDLE;
      endcase
    end
  end

  // Outputs to CPU and system integration logic
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      breakpoint_request <= 1'b0;
      break_vector <= ABU_VEC_NORMAL;
      software_interrupt_opcode <= ABU_SWI_OPCODE;
      in_break <= 1'b0;
      timer_halt <= 1'b0;
      watchdog_suppress <= 1'b0;
      flag_clear_allowed <= 1'b1;
    end
    else
    begin
      breakpoint_request <= (state == ABU_PEND);
      break_vector <= sys.monitor_mode ? ABU_VEC_MONITOR : ABU_VEC_NORMAL;
      software_interrupt_opcode <= ABU_SWI_OPCODE;
      in_break <= (state == ABU_BREAK);
      timer_halt <= (state == ABU_BREAK);
      watchdog_suppress <= (state == ABU_BREAK) && sys.monitor_mode &&
        break_watchdog_disable;
      flag_clear_allowed <= (state != ABU_BREAK) || break_flag_clear_enable;
    end
  end

  // APB slave: zero wait states, error on unmapped address
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          ABU_OFF_CTRL:
            prdata[7:6] <= {break_enable_bit, break_active_bit};
          ABU_OFF_ADDR_HI:
            prdata[7:0] <= break_address_high;
          ABU_OFF_ADDR_LO:
            prdata[7:0] <= break_address_low;
          ABU_OFF_AUX:
            prdata[ABU_BIT_WDOG_DIS] <= break_watchdog_disable;
          ABU_OFF_WAIT_STAT:
            prdata[ABU_BIT_WAIT_EXIT] <= wait_exit_by_break_flag;
          ABU_OFF_FLAG_CTRL:
            prdata[ABU_BIT_CLR_EN] <= break_flag_clear_enable;
          default:
            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  AST_NO_LOWPOWER_HIT: assert property (@(posedge clk) disable iff (!rst_n)
    (sys.wait_mode || sys.stop_mode) |-> !addr_hit)
    else $error("Break hit in low power mode");
  AST_MATCH_SETS_ACTIVE: assert property (@(posedge clk) disable iff (!rst_n)
    addr_hit |=> break_active_bit)
    else $error("Match did not set active bit");
  AST_MATCH_NEEDS_ENABLE: assert property (@(posedge clk) disable iff (!rst_n)
    (addr_hit && state == ABU_IDLE) |-> break_enable_bit ##1 state == ABU_PEND)
    else $error("Match without enable or no pend");
  AST_REQ_FOLLOWS_PEND: assert property (@(posedge clk) disable iff (!rst_n)
    state == ABU_PEND |=> breakpoint_request)
    else $error("Request not raised");
  AST_SW_BREAK: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ABU_IDLE && wr_acc && paddr == ABU_OFF_CTRL && pwdata[ABU_BIT_ACTIVE])
    |=> state == ABU_PEND)
    else $error("Software break not pended");
  AST_BOUNDARY: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ABU_PEND && !cpu.instr_boundary) |=> state == ABU_PEND)
    else $error("Break taken off instruction boundary");
  AST_RTI_ENDS: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ABU_BREAK && cpu.rti_done) |=> state == ABU_IDLE ##1 !timer_halt)
    else $error("Return did not end break");
  AST_TIMER_HALT: assert property (@(posedge clk) disable iff (!rst_n)
    state == ABU_BREAK |=> timer_halt)
    else $error("Timer not halted");
  AST_FLAG_BLOCK: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ABU_BREAK && !break_flag_clear_enable) |=> !flag_clear_allowed)
    else $error("Flag clear not blocked");
  AST_WDOG: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ABU_BREAK && sys.monitor_mode && break_watchdog_disable)
    |=> watchdog_suppress)
    else $error("Watchdog not suppressed");
  AST_DISARM: assert property (@(posedge clk) disable iff (!rst_n)
    !armed |-> !addr_hit)
    else $error("Disarmed unit hit");


  // Register and output checks
  AST_VEC_MONITOR: assert property (@(posedge clk) disable iff (!rst_n)
    sys.monitor_mode |=> break_vector == ABU_VEC_MONITOR)
    else $error("Monitor vector not selected");
  AST_VEC_NORMAL: assert property (@(posedge clk) disable iff (!rst_n)
    !sys.monitor_mode |=> break_vector == ABU_VEC_NORMAL)
    else $error("Normal vector not selected");
  AST_ACTIVE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == ABU_OFF_CTRL && !pwdata[ABU_BIT_ACTIVE] && !addr_hit)
    |=> !break_active_bit)
    else $error("Active bit not cleared by write");
  AST_ENABLE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == ABU_OFF_CTRL) |=> break_enable_bit == $past(pwdata[ABU_BIT_ENABLE]))
    else $error("Enable bit write lost");
  AST_NO_HIT_DISABLED: assert property (@(posedge clk) disable iff (!rst_n)
    !break_enable_bit |-> !addr_hit)
    else $error("Match while disabled");
  AST_DISARM_ON_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == ABU_OFF_CTRL && !pwdata[ABU_BIT_ACTIVE] && state == ABU_BREAK)
    |=> !armed)
    else $error("Clear in break did not disarm");
  AST_REARM: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && (paddr == ABU_OFF_ADDR_HI || paddr == ABU_OFF_ADDR_LO)) |=> armed)
    else $error("Address write did not rearm");
  AST_ADDR_HI_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == ABU_OFF_ADDR_HI) |=> break_address_high == $past(pwdata[7:0]))
    else $error("High address write lost");
  AST_ADDR_LO_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == ABU_OFF_ADDR_LO) |=> break_address_low == $past(pwdata[7:0]))
    else $error("Low address write lost");
  AST_AUX_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == ABU_OFF_AUX)
    |=> break_watchdog_disable == $past(pwdata[ABU_BIT_WDOG_DIS]))
    else $error("Watchdog disable write lost");
  AST_IN_BREAK: assert property (@(posedge clk) disable iff (!rst_n)
    state == ABU_BREAK |=> in_break)
    else $error("Break state not shown");
  AST_REQ_DROP: assert property (@(posedge clk) disable iff (!rst_n)
    state == ABU_BREAK |=> !breakpoint_request)
    else $error("Request held in break");
  AST_WAIT_EXIT_SET: assert property (@(posedge clk) disable iff (!rst_n)
    (sys.emulation_mode && sys.wait_exit && state == ABU_PEND) |=> wait_exit_by_break_flag)
    else $error("Wait-exit flag not set");
  AST_WAIT_EXIT_CLR: assert property (@(posedge clk) disable iff (!rst_n)
    state == ABU_IDLE |=> !wait_exit_by_break_flag)
    else $error("Wait-exit flag not cleared");
  AST_FLAG_ALLOW: assert property (@(posedge clk) disable iff (!rst_n)
    state != ABU_BREAK |=> flag_clear_allowed)
    else $error("Flag clear blocked outside break");
  AST_WDOG_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    state != ABU_BREAK |=> !watchdog_suppress)
    else $error("Watchdog suppressed outside break");
  AST_TIMER_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    state != ABU_BREAK |=> !timer_halt)
    else $error("Timer halted outside break");

  COV_MONITOR_BREAK: cover property (@(posedge clk) disable iff (!rst_n)
    in_break && watchdog_suppress);
  COV_WAIT_EXIT: cover property (@(posedge clk) disable iff (!rst_n)
    in_break && wait_exit_by_break_flag);
  COV_ADDR_BREAK: cover property (@(posedge clk) disable iff (!rst_n)
    addr_hit ##[1:20] state == ABU_BREAK);
  COV_SW_BREAK: cover property (@(posedge clk) disable iff (!rst_n)
    (wr_acc && paddr == ABU_OFF_CTRL && pwdata[ABU_BIT_ACTIVE]) ##[1:20] in_break);
  COV_RTI: cover property (@(posedge clk) disable iff (!rst_n)
    state == ABU_BREAK ##1 state == ABU_IDLE);
endmodule

// ---- test/abu_cpu_model.sv ----
// CPU model facing the breakpoint unit; the testbench drives the system mode inputs itself
`timescale 1ns/100ps
module abu_cpu_model
  import abu_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] addr_in,
  input wire logic fetch_in,
  input wire logic do_rti,
  input wire logic breakpoint_request,
  input wire logic in_break,
  output abu_pkg::abu_cpu_t cpu
);
  import abu_pkg::*;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpu <= '0;
    end
    else
    begin
      cpu.addr <= addr_in;
      // No program fetch from the user address while the break is pending or served
      cpu.opcode_fetch <= fetch_in && !in_break && !breakpoint_request;
      // Boundary reached right after the request: the stalled opcode waits
      cpu.instr_boundary <= breakpoint_request && !cpu.instr_boundary;
      cpu.rti_done <= do_rti && in_break && !cpu.rti_done;
    end
  end
endmodule

// ---- test/tb.sv ----
// Self-checking testbench for the address breakpoint unit
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
  import abu_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, breakpoint_request, in_break;
  logic timer_halt, watchdog_suppress, flag_clear_allowed, fetch_in, do_rti, rerr;
  logic [7:0] paddr, software_interrupt_opcode;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] break_vector, addr_in;
  abu_cpu_t cpu;
  abu_sys_t sys;
  int n_fail = 0, checks_done = 0, cyc = 0, i;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} abu_row_t;
  abu_row_t rows [5] = '{
    '{ABU_OFF_ADDR_HI, 32'h1234_56A5, 32'h0000_00A5, 1'b0},
    '{ABU_OFF_ADDR_LO, 32'hFFFF_FF5A, 32'h0000_005A, 1'b0},
    '{ABU_OFF_AUX, 32'h0000_0001, 32'h0000_0001, 1'b0},
    '{ABU_OFF_FLAG_CTRL, 32'h0000_0080, 32'h0000_0080, 1'b0},
    '{8'h18, 32'h0000_00FF, 32'h0000_0000, 1'b1}};
  abu_top uut (.clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cpu, .sys, .breakpoint_request, .break_vector, .software_interrupt_opcode,
    .in_break, .timer_halt, .watchdog_suppress, .flag_clear_allowed);
  abu_cpu_model partner (.clk, .arst_n, .addr_in, .fetch_in, .do_rti, .breakpoint_request,
    .in_break, .cpu);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("mismatches=%0d comparisons=%0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    `CHK(pready, 1'b1)
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_brk(input logic e);
    int k;
    for (k = 0; k < 12 && in_break !== e; k++) @(posedge clk);
  endtask
  task automatic quiet(input int n);
    int k;
    for (k = 0; k < n; k++)
    begin
      @(posedge clk);
      `CHK(breakpoint_request | in_break, 1'b0)
    end
  endtask
  task automatic leave();
    apb(1'b1, ABU_OFF_CTRL, 32'h0000_0080);
    do_rti <= 1'b1;
    @(posedge clk);
    do_rti <= 1'b0;
    wait_brk(1'b0);
    `CHK({in_break, timer_halt}, 2'b00)
  endtask
  initial
  begin
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    addr_in = '0; fetch_in = 1'b0; do_rti = 1'b0; sys = '0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK({break_vector, software_interrupt_opcode}, {ABU_VEC_NORMAL, ABU_SWI_OPCODE})
    `CHK({breakpoint_request, in_break, timer_halt, flag_clear_allowed}, 4'b0001)
    apb(1'b0, ABU_OFF_CTRL, '0); `CHK(rdat, 32'h0000_0000)
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, rows[i].a, '0); `CHK(rdat, 32'h0000_0000)
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, '0); `CHK({rdat, rerr}, {rows[i].r, rows[i].e})
    end
    // Break address 16'hA55A with the enable bit still clear
    addr_in <= 16'hA55A; fetch_in <= 1'b1; quiet(6);
    fetch_in <= 1'b0;
    apb(1'b1, ABU_OFF_CTRL, 32'h0000_0080); quiet(6);
    fetch_in <= 1'b1; wait_brk(1'b1);
    `CHK({in_break, timer_halt, watchdog_suppress, break_vector}, {3'b110, ABU_VEC_NORMAL})
    apb(1'b0, ABU_OFF_CTRL, '0); `CHK({rdat, flag_clear_allowed}, {32'h0000_00C0, 1'b1})
    leave(); quiet(8);
    // Monitor mode, clear-enable off, new address rearms
    apb(1'b1, ABU_OFF_FLAG_CTRL, '0); sys.monitor_mode <= 1'b1;
    apb(1'b1, ABU_OFF_ADDR_LO, 32'h0000_005B); addr_in <= 16'hA55B; wait_brk(1'b1);
    `CHK({in_break, watchdog_suppress, flag_clear_allowed, break_vector}, {3'b110, ABU_VEC_MONITOR})
    leave(); fetch_in <= 1'b0; sys <= '0;
    // Software break with enable clear, leaving wait in emulation
    apb(1'b1, ABU_OFF_CTRL, '0); sys.emulation_mode <= 1'b1; sys.wait_exit <= 1'b1;
    apb(1'b1, ABU_OFF_CTRL, 32'h0000_0040); wait_brk(1'b1); `CHK(in_break, 1'b1)
    apb(1'b0, ABU_OFF_WAIT_STAT, '0); `CHK(rdat, 32'h0000_0002)
    leave(); sys <= '0;
    apb(1'b0, ABU_OFF_WAIT_STAT, '0); `CHK(rdat, 32'h0000_0000)
    // Frozen bus in wait and stop
    sys <= '{wait_mode: 1'b1, default: 1'b0};
    apb(1'b1, ABU_OFF_ADDR_LO, 32'h0000_005A); addr_in <= 16'hA55A; fetch_in <= 1'b1; quiet(6);
    sys <= '{stop_mode: 1'b1, default: 1'b0}; quiet(6);
    sys <= '0; wait_brk(1'b1); `CHK(in_break, 1'b1)
    fetch_in <= 1'b0; leave();
    // Reset in mid-run clears the registers
    arst_n <= 1'b0; @(posedge clk); arst_n <= 1'b1; repeat (3) @(posedge clk);
    apb(1'b0, ABU_OFF_CTRL, '0); `CHK(rdat, 32'h0000_0000)
    apb(1'b0, ABU_OFF_ADDR_LO, '0); `CHK(rdat, 32'h0000_0000)
    print_verdict();
  end
endmodule
